// File: design/parallel_video_input_3d.sv
// parallel rgb video input with 3d eye tagging and sync loss watchdog
// assumes the source drives all pins from its own pixel clock
`timescale 1ns/1ps
module parallel_video_input_3d
  import video_in_pkg::*;
#(
  parameter int VSYNC_LOSS = VSYNC_LOSS_CYCLES
)
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              pclk_in,
  input  wire logic              vsync_in,
  input  wire logic              hsync_in,
  input  wire logic              pixel_valid_in,
  input  wire logic [PIX_W-1:0]  pixel_bus_in,
  input  wire logic              sub_frame_in,
  input  wire logic              eye_select_in,
  input  wire logic              vsync_pol_in,
  input  wire logic              hsync_pol_in,
  input  wire logic              fall_edge_in,
  input  wire logic              use_valid_in,
  input  wire logic              init_done_in,
  input  wire logic              lock_vsync_in,
  input  wire logic              glasses_en_in,
  output logic                   pix_valid_out,
  output logic [COMP_W-1:0]      red_out,
  output logic [COMP_W-1:0]      green_out,
  output logic [COMP_W-1:0]      blue_out,
  output logic                   frame_start_out,
  output logic                   eye_out,
  output logic                   sub_frame_out,
  output logic                   glasses_sync_out,
  output logic                   seq_run_out,
  output logic                   led_on_out,
  output logic                   res_error_out
);
  localparam logic [WD_W-1:0] WD_LIMIT = WD_W'(VSYNC_LOSS);

  pixel_link_if lk ();

  video_capture video_capture_i (
    .pclk_in        (pclk_in),
    .rst_in         (rst_in),
    .vsync_in       (vsync_in),
    .hsync_in       (hsync_in),
    .pixel_valid_in (pixel_valid_in),
    .pixel_bus_in   (pixel_bus_in),
    .sub_frame_in   (sub_frame_in),
    .eye_select_in  (eye_select_in),
    .cfg_in         ({init_done_in, use_valid_in, fall_edge_in,
                      hsync_pol_in, vsync_pol_in}),
    .link           (lk.src)
  );

  // saturating increment shared by the pixel counters
  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
    inc_sat = (v == CNT_SAT) ? v : v + 12'h001;
  endfunction

  // ---------------- pixel clock domain ----------------
  logic [CNT_W-1:0]  col_reg, row_reg, wid_reg;
  logic [CNT_W-1:0]  col_next, row_next, wid_next;
  logic              portrait_reg, clip_reg, err_reg;
  logic              portrait_next, clip_next, err_next;
  logic              pv_reg, fs_reg, eye_reg, sf_reg;
  logic              pv_next;
  logic [PIX_W-1:0]  rgb_reg;
  logic              in_range;

  // geometry tracking, limits and orientation check
  always_comb
  begin
    col_next      = col_reg;
    row_next      = row_reg;
    wid_next      = wid_reg;
    portrait_next = portrait_reg;
    clip_next     = clip_reg;
    err_next      = err_reg;
    in_range = (col_reg < MAX_H) && (row_reg < MAX_V);
    if (lk.sof)
    begin
      // previous frame decides; taller than wide means portrait
      portrait_next = (wid_reg != '0) && (wid_reg < row_reg);
      err_next      = portrait_next | clip_reg;
      col_next      = '0;
      row_next      = '0;
      wid_next      = '0;
      clip_next     = 1'h0;
    end
    else
    begin
      if (lk.sol && col_reg != '0)
      begin
        row_next = inc_sat(row_reg);
        col_next = '0;
      end
      else if (lk.valid)
      begin
        col_next = inc_sat(col_reg);
        if (col_next > wid_reg)
          wid_next = col_next;
        if (!in_range)
          clip_next = 1'h1;
      end
    end
    pv_next = lk.valid & in_range & ~portrait_reg & ~lk.sof;
  end

  // pixels pass straight through, one out frame per in frame
  always_ff @(posedge pclk_in or posedge lk.rst_pix)
    if (lk.rst_pix)
    begin
      col_reg      <= '0;
      row_reg      <= '0;
      wid_reg      <= '0;
      portrait_reg <= 1'h0;
      clip_reg     <= 1'h0;
      err_reg      <= 1'h0;
      pv_reg       <= 1'h0;
      fs_reg       <= 1'h0;
      eye_reg      <= EYE_RIGHT;
      sf_reg       <= 1'h0;
      rgb_reg      <= '0;
    end
    else
    begin
      col_reg      <= col_next;
      row_reg      <= row_next;
      wid_reg      <= wid_next;
      portrait_reg <= portrait_next;
      clip_reg     <= clip_next;
      err_reg      <= err_next;
      pv_reg       <= pv_next;
      fs_reg       <= lk.sof;
      eye_reg      <= lk.eye;
      sf_reg       <= lk.sub_frame;
      rgb_reg      <= lk.rgb;
    end

  assign pix_valid_out   = pv_reg;
  assign red_out         = rgb_reg[RED_HI:RED_LO];
  assign green_out       = rgb_reg[GRN_HI:GRN_LO];
  assign blue_out        = rgb_reg[BLU_HI:BLU_LO];
  assign frame_start_out = fs_reg;
  assign eye_out         = eye_reg;
  assign sub_frame_out   = sf_reg;

  // ---------------- system clock domain ----------------
  logic [2:0]       tog_sync_reg;
  logic [1:0]       eye_sync_reg;
  logic [1:0]       err_sync_reg;
  logic [WD_W-1:0]  wd_reg, wd_next;
  logic             run_reg, run_next, glasses_reg, glasses_next;
  logic             vs_event;

  // frame sync event, eye and error levels cross in two stages
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      tog_sync_reg <= '0;
      eye_sync_reg <= '0;
      err_sync_reg <= '0;
    end
    else
    begin
      tog_sync_reg <= {tog_sync_reg[1:0], lk.vs_toggle};
      eye_sync_reg <= {eye_sync_reg[0], eye_reg};
      err_sync_reg <= {err_sync_reg[0], err_reg};
    end
  assign vs_event = tog_sync_reg[2] ^ tog_sync_reg[1];

  // watchdog: losing a locked frame sync halts the sequencer
  always_comb
  begin
    if (vs_event)
      wd_next = '0;
    else if (wd_reg != WD_LIMIT)
      wd_next = wd_reg + 22'h000001;
    else
      wd_next = wd_reg;
    // locked mode only: a free-running source may pause its frame sync
    run_next = init_done_in &
               ~(lock_vsync_in & (wd_reg == WD_LIMIT));
    glasses_next = glasses_en_in & eye_sync_reg[1];
  end

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      wd_reg      <= '0;
      run_reg     <= 1'h0;
      glasses_reg <= 1'h0;
    end
    else
    begin
      wd_reg      <= wd_next;
      run_reg     <= run_next;
      glasses_reg <= glasses_next;
    end

  assign seq_run_out      = run_reg;
  assign led_on_out       = run_reg;
  assign glasses_sync_out = glasses_reg;
  assign res_error_out    = err_sync_reg[1];

  // checks on the output side
  property p_limits;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      lk.valid && !in_range |=> !pix_valid_out;
  endproperty
  a_limits: assert property (p_limits)
    else $error("pixel beyond 1920x1080 passed");

  property p_portrait;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      portrait_reg |=> !pix_valid_out;
  endproperty
  a_portrait: assert property (p_portrait)
    else $error("portrait frame passed");

  property p_rate;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      lk.sof |=> frame_start_out ##1 !frame_start_out;
  endproperty
  a_rate: assert property (p_rate)
    else $error("output frame start not one per input frame");

  property p_rgb;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      pix_valid_out |-> {red_out, green_out, blue_out} == $past(lk.rgb);
  endproperty
  a_rgb: assert property (p_rgb)
    else $error("rgb components misplaced");

  property p_loss;
    @(posedge clk_in) disable iff (rst_in)
      lock_vsync_in && wd_reg == WD_LIMIT |=> !seq_run_out && !led_on_out;
  endproperty
  a_loss: assert property (p_loss)
    else $error("sequencer kept running after sync loss");

  property p_glasses;
    @(posedge clk_in) disable iff (rst_in)
      !glasses_en_in |=> !glasses_sync_out;
  endproperty
  a_glasses: assert property (p_glasses)
    else $error("glasses sync driven while disabled");

  property p_run_init;
    @(posedge clk_in) disable iff (rst_in)
      !init_done_in |=> !seq_run_out;
  endproperty
  a_run_init: assert property (p_run_init)
    else $error("sequencer running before init done");

  property p_run_back;
    @(posedge clk_in) disable iff (rst_in)
      vs_event && init_done_in ##1 init_done_in |=> seq_run_out;
  endproperty
  a_run_back: assert property (p_run_back)
    else $error("sequencer not restarted by frame sync");

  property p_wd_clear;
    @(posedge clk_in) disable iff (rst_in)
      vs_event |=> wd_reg == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("watchdog not cleared by frame sync");

  property p_glasses_on;
    @(posedge clk_in) disable iff (rst_in)
      glasses_en_in && eye_sync_reg[1] |=> glasses_sync_out;
  endproperty
  a_glasses_on: assert property (p_glasses_on)
    else $error("glasses sync missing for left eye");

  property p_pix_frame;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      frame_start_out |-> !pix_valid_out;
  endproperty
  a_pix_frame: assert property (p_pix_frame)
    else $error("pixel passed on a frame start");

  property p_clip_err;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      lk.sof && clip_reg |=> err_reg;
  endproperty
  a_clip_err: assert property (p_clip_err)
    else $error("clipped frame not flagged");

  property p_portrait_err;
    @(posedge pclk_in) disable iff (lk.rst_pix)
      lk.sof && wid_reg != '0 && wid_reg < row_reg
        |=> portrait_reg && err_reg;
  endproperty
  a_portrait_err: assert property (p_portrait_err)
    else $error("portrait frame not flagged");

  c_loss: cover property (@(posedge clk_in) seq_run_out ##1 !seq_run_out);
  c_eye: cover property (@(posedge clk_in)
    glasses_sync_out ##1 !glasses_sync_out);
  c_clip: cover property (@(posedge pclk_in) lk.valid && !in_range);
  c_portrait: cover property (@(posedge pclk_in) portrait_reg && lk.valid);
endmodule

// File: design/video_in_pkg.sv
// constants shared by the parallel video input and its capture stage
// assumes a 50 MHz system clock and a source-driven pixel clock
// Operation
// - eye select high means left eye, low means right eye.
// - one output frame per input frame, no frame rate conversion.
// - optional glasses sync output in phase with the displayed eye.
// - port is frame sync, line sync, optional valid, 24-bit bus, clock.
// - both sync polarities and the sampling clock edge are programmable.
// - locked frame sync must keep running, else sequencer and leds stop.
// - pixel bus always carries 8-bit red, green and blue.
// - only landscape source images are accepted; the code passes a portrait frame and blocks the frame after it.
// - displayed resolution limited to 1920 by 1080.
// - a pixel may span several clocks on fewer lines.
// - video is ignored until auto-initialization has finished.
package video_in_pkg;
  localparam int PIX_W   = 24;
  localparam int COMP_W  = 8;
  localparam int RED_HI  = 23;
  localparam int RED_LO  = 16;
  localparam int GRN_HI  = 15;
  localparam int GRN_LO  = 8;
  localparam int BLU_HI  = 7;
  localparam int BLU_LO  = 0;
  // sampled pin vector layout: pixel bus in the low bits
  localparam int SMP_W   = 29;
  localparam int S_VS    = 24;
  localparam int S_HS    = 25;
  localparam int S_DE    = 26;
  localparam int S_SF    = 27;
  localparam int S_EYE   = 28;
  // configuration vector layout
  localparam int CFG_W     = 5;
  localparam int CFG_VPOL  = 0;
  localparam int CFG_HPOL  = 1;
  localparam int CFG_FALL  = 2;
  localparam int CFG_USEDE = 3;
  localparam int CFG_INIT  = 4;
  localparam logic EYE_LEFT  = 1'h1;
  localparam logic EYE_RIGHT = 1'h0;
  // resolution limits
  localparam int          CNT_W = 12;
  localparam logic [11:0] MAX_H = 12'h780;
  localparam logic [11:0] MAX_V = 12'h438;
  localparam logic [11:0] CNT_SAT = 12'hfff;
  // frame sync loss timeout
  localparam int SYS_CLK_HZ    = 50_000_000;
  localparam int VSYNC_LOSS_MS = 50;
  localparam int VSYNC_LOSS_CYCLES = SYS_CLK_HZ / 1000 * VSYNC_LOSS_MS;
  localparam int WD_W = 22;
endpackage

// File: design/pixel_link_if.sv
// carrier between the capture stage and the pixel output logic
// all signals live in the pixel clock domain
`timescale 1ns/1ps
interface pixel_link_if;
  logic        rst_pix;
  logic        valid;
  logic [23:0] rgb;
  logic        sof;
  logic        sol;
  logic        eye;
  logic        sub_frame;
  logic        vs_toggle;
  modport src (output rst_pix, valid, rgb, sof, sol, eye, sub_frame,
               vs_toggle);
  modport dst (input rst_pix, valid, rgb, sof, sol, eye, sub_frame,
               vs_toggle);
endinterface

// File: design/video_capture.sv
// pin capture for the parallel video port, on the pixel clock
// assumes config levels come from the system clock domain
`timescale 1ns/1ps
module video_capture
  import video_in_pkg::*;
(
  input  wire logic              pclk_in,
  input  wire logic              rst_in,
  input  wire logic              vsync_in,
  input  wire logic              hsync_in,
  input  wire logic              pixel_valid_in,
  input  wire logic [PIX_W-1:0]  pixel_bus_in,
  input  wire logic              sub_frame_in,
  input  wire logic              eye_select_in,
  input  wire logic [CFG_W-1:0]  cfg_in,
  pixel_link_if.src              link
);
  logic [1:0]       rst_sync_reg;
  logic [CFG_W-1:0] cfg_meta_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic [SMP_W-1:0] pins;
  logic [SMP_W-1:0] neg_reg;
  logic [SMP_W-1:0] smp_reg;
  logic [SMP_W-1:0] smp_next;
  logic             vs_prev_reg, hs_prev_reg, en_reg, eye_reg;
  logic             valid_reg, sof_reg, sol_reg, sf_reg, tog_reg;
  logic [PIX_W-1:0] rgb_reg;
  logic             vs_prev_next, hs_prev_next, en_next, eye_next;
  logic             valid_next, sof_next, sol_next, tog_next;
  logic             vs_act, hs_act, sof_w, act;

  // reset release aligned to the pixel clock
  always_ff @(posedge pclk_in or posedge rst_in)
    if (rst_in)
      rst_sync_reg <= 2'h3;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'h0};
  assign link.rst_pix = rst_sync_reg[1];

  // config crosses from the system clock, two stages
  always_ff @(posedge pclk_in or posedge rst_in)
    if (rst_in)
    begin
      cfg_meta_reg <= '0;
      cfg_reg      <= '0;
    end
    else
    begin
      cfg_meta_reg <= cfg_in;
      cfg_reg      <= cfg_meta_reg;
    end

  assign pins = {eye_select_in, sub_frame_in, pixel_valid_in, hsync_in,
                 vsync_in, pixel_bus_in};

  // falling edge capture, chosen below per config
  always_ff @(negedge pclk_in or posedge link.rst_pix)
    if (link.rst_pix)
      neg_reg <= '0;
    else
      neg_reg <= pins;

  // sync decode, init gating and eye latch
  always_comb
  begin
    smp_next = cfg_reg[CFG_FALL] ? neg_reg : pins;
    vs_act = (smp_reg[S_VS] == cfg_reg[CFG_VPOL]);
    hs_act = (smp_reg[S_HS] == cfg_reg[CFG_HPOL]);
    sof_w = vs_act & ~vs_prev_reg;
    vs_prev_next = vs_act;
    hs_prev_next = hs_act;
    // acceptance starts only on a whole frame after init
    if (!cfg_reg[CFG_INIT])
      en_next = 1'h0;
    else if (sof_w)
      en_next = 1'h1;
    else
      en_next = en_reg;
    eye_next = sof_w ? smp_reg[S_EYE] : eye_reg;
    // without the qualifier, blanking comes from the syncs
    act = cfg_reg[CFG_USEDE] ? smp_reg[S_DE] : (~vs_act & ~hs_act);
    valid_next = en_reg & cfg_reg[CFG_INIT] & act;
    sof_next = sof_w & en_next;
    sol_next = hs_act & ~hs_prev_reg;
    tog_next = tog_reg ^ sof_w;
  end

  always_ff @(posedge pclk_in or posedge link.rst_pix)
    if (link.rst_pix)
    begin
      smp_reg     <= '0;
      // held as if active so no false edge follows reset
      vs_prev_reg <= 1'h1;
      hs_prev_reg <= 1'h1;
      en_reg      <= 1'h0;
      eye_reg     <= EYE_RIGHT;
      valid_reg   <= 1'h0;
      sof_reg     <= 1'h0;
      sol_reg     <= 1'h0;
      sf_reg      <= 1'h0;
      tog_reg     <= 1'h0;
      rgb_reg     <= '0;
    end
    else
    begin
      smp_reg     <= smp_next;
      vs_prev_reg <= vs_prev_next;
      hs_prev_reg <= hs_prev_next;
      en_reg      <= en_next;
      eye_reg     <= eye_next;
      valid_reg   <= valid_next;
      sof_reg     <= sof_next;
      sol_reg     <= sol_next;
      sf_reg      <= smp_reg[S_SF];
      tog_reg     <= tog_next;
      rgb_reg     <= smp_reg[PIX_W-1:0];
    end

  assign link.valid     = valid_reg;
  assign link.rgb       = rgb_reg;
  assign link.sof       = sof_reg;
  assign link.sol       = sol_reg;
  assign link.eye       = eye_reg;
  assign link.sub_frame = sf_reg;
  assign link.vs_toggle = tog_reg;

  // checks on the capture stage
  property p_init_gate;
    @(posedge pclk_in) disable iff (link.rst_pix)
      !cfg_reg[CFG_INIT] |=> !link.valid;
  endproperty
  a_init_gate: assert property (p_init_gate)
    else $error("pixel accepted before init done");

  property p_sync_blank;
    @(posedge pclk_in) disable iff (link.rst_pix)
      !cfg_reg[CFG_USEDE] && (vs_act || hs_act) |=> !link.valid;
  endproperty
  a_sync_blank: assert property (p_sync_blank)
    else $error("pixel accepted during sync");

  property p_sof_pol;
    @(posedge pclk_in) disable iff (link.rst_pix)
      vs_act && !vs_prev_reg && en_reg |=> link.sof;
  endproperty
  a_sof_pol: assert property (p_sof_pol)
    else $error("frame start missed on active sync edge");

  property p_eye_latch;
    @(posedge pclk_in) disable iff (link.rst_pix)
      sof_w |=> link.eye == $past(smp_reg[S_EYE]);
  endproperty
  a_eye_latch: assert property (p_eye_latch)
    else $error("eye not latched at frame start");

  c_frame: cover property (@(posedge pclk_in) link.sof ##[1:300] link.valid);
endmodule

// File: verification/video_source_model.sv
// source-side model: drives the parallel pixel pins from its own clock
// assumes the bench calls its tasks; its clock rests low between frames
`timescale 1ns/1ps
module video_source_model
  import video_in_pkg::*;
#(
  parameter int EYE_LEAD_NS = 1000000
)
(
  output logic             pclk_out,
  output logic             vsync_out,
  output logic             hsync_out,
  output logic             valid_out,
  output logic [PIX_W-1:0] pixel_bus_out,
  output logic             sub_frame_out,
  output logic             eye_select_out
);
  logic vp;
  logic hp;
  logic fe;
  // quiet pins at start
  initial
  begin
    pclk_out = 1'h0;
    valid_out = 1'h0;
    pixel_bus_out = 24'h000000;
    sub_frame_out = 1'h0;
    eye_select_out = 1'h0;
  end
  // sync polarity and sampled edge, as the device is set up
  task automatic cfg(input logic v, h, f);
    vp = v;
    hp = h;
    fe = f;
    vsync_out = ~v;
    hsync_out = h;
  endtask
  // one pixel clock; pins change on the edge that is not sampled
  task automatic tick(input logic vs, hs, dv, input logic [PIX_W-1:0] d);
    if (fe)
      pclk_out = 1'h1;
    vsync_out = vs ? vp : ~vp;
    hsync_out = hs ? hp : ~hp;
    valid_out = dv;
    pixel_bus_out = d;
    #24;
    pclk_out = ~fe;
    #24;
    pclk_out = 1'h0;
  endtask
  // line sync held active, bus toggling so stale data never matches
  task automatic idle(input int n);
    repeat (n) tick(1'h0, 1'h1, 1'h0, ~pixel_bus_out);
  endtask
  // one single-eye frame: frame sync, then lines with no front porch
  task automatic send_frame(input logic e, sf, dv, input int w, l);
    eye_select_out = e;
    #(EYE_LEAD_NS);
    sub_frame_out = sf;
    idle(4);
    repeat (2) tick(1'h1, 1'h0, 1'h0, ~pixel_bus_out);
    for (int y = 0; y < l; y++)
    begin
      idle(2);
      for (int x = 0; x < w; x++)
        tick(1'h0, 1'h0, dv,
             {8'(y + 1), 8'(x), 8'(x) ^ 8'ha5});
    end
    idle(8);
  endtask
endmodule

// File: verification/parallel_video_input_3d_tb_top.sv
// self-checking bench for the parallel video input with 3d tagging
// assumes the source model above stands on the pixel pins
`timescale 1ns/1ps
module parallel_video_input_3d_tb_top;
  import video_in_pkg::*;
  localparam int LOSS = 200;
  logic             clk_in, rst_in, pclk_in, vsync_in, hsync_in;
  logic             pixel_valid_in, sub_frame_in, eye_select_in;
  logic [PIX_W-1:0] pixel_bus_in;
  logic             vsync_pol_in, hsync_pol_in, fall_edge_in;
  logic             use_valid_in, init_done_in, lock_vsync_in;
  logic             glasses_en_in, pix_valid_out, frame_start_out;
  logic [7:0]       red_out, green_out, blue_out;
  logic             eye_out, sub_frame_out, glasses_sync_out;
  logic             seq_run_out, led_on_out, res_error_out;
  int               err_total, checks_done, pix_cnt, fs_cnt;
  logic [PIX_W-1:0] last_pix;

  parallel_video_input_3d #(.VSYNC_LOSS(LOSS)) parallel_video_input_3d_i (
    .clk_in(clk_in), .rst_in(rst_in), .pclk_in(pclk_in),
    .vsync_in(vsync_in), .hsync_in(hsync_in),
    .pixel_valid_in(pixel_valid_in), .pixel_bus_in(pixel_bus_in),
    .sub_frame_in(sub_frame_in), .eye_select_in(eye_select_in),
    .vsync_pol_in(vsync_pol_in), .hsync_pol_in(hsync_pol_in),
    .fall_edge_in(fall_edge_in), .use_valid_in(use_valid_in),
    .init_done_in(init_done_in), .lock_vsync_in(lock_vsync_in),
    .glasses_en_in(glasses_en_in), .pix_valid_out(pix_valid_out),
    .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
    .frame_start_out(frame_start_out), .eye_out(eye_out),
    .sub_frame_out(sub_frame_out), .glasses_sync_out(glasses_sync_out),
    .seq_run_out(seq_run_out), .led_on_out(led_on_out),
    .res_error_out(res_error_out));

  // shortened eye lead keeps the run short; device latches at frame sync
  video_source_model #(.EYE_LEAD_NS(2000)) video_source_model_i (
    .pclk_out(pclk_in), .vsync_out(vsync_in), .hsync_out(hsync_in),
    .valid_out(pixel_valid_in), .pixel_bus_out(pixel_bus_in),
    .sub_frame_out(sub_frame_in), .eye_select_out(eye_select_in));

  // system clock
  initial
  begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end

  // output monitor in the pixel clock domain
  always @(posedge pclk_in)
  begin
    if (pix_valid_out === 1'h1)
    begin
      pix_cnt <= pix_cnt + 1;
      last_pix <= {red_out, green_out, blue_out};
    end
    if (frame_start_out === 1'h1)
      fs_cnt <= fs_cnt + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // config changes need pixel clocks to cross into the capture stage
  task automatic set_cfg(input logic v, h, f, u);
    @(negedge clk_in);
    vsync_pol_in = v;
    hsync_pol_in = h;
    fall_edge_in = f;
    use_valid_in = u;
    video_source_model_i.cfg(v, h, f);
    video_source_model_i.idle(6);
  endtask

  // counters cleared while the pixel clock stands still
  task automatic frame(input logic e, sf, dv, input int w, l);
    pix_cnt = 0;
    fs_cnt = 0;
    video_source_model_i.send_frame(e, sf, dv, w, l);
    repeat (8) @(negedge clk_in);
  endtask

  // width beyond the limit is clipped; fs below zero skips that compare
  task automatic expect_px(input int fs, w, l);
    int wc;
    logic [PIX_W-1:0] lp;
    wc = (w > 1920) ? 1920 : w;
    if (fs >= 0)
      check("frame_start", fs_cnt, fs);
    check("pixels", pix_cnt, wc * l);
    if (wc * l > 0)
    begin
      lp = {8'(l), 8'(wc - 1), 8'(wc - 1) ^ 8'ha5};
      check("last_rgb", last_pix, lp);
    end
  endtask

  task automatic t_init_gate;
    frame(EYE_LEFT, 1'h0, 1'h1, 8, 4);
    expect_px(0, 0, 0);
    check("seq_run", seq_run_out, 1'h0);
    @(negedge clk_in);
    init_done_in = 1'h1;
    frame(EYE_LEFT, 1'h1, 1'h1, 8, 4);
    expect_px(1, 8, 4);
    check("eye", eye_out, EYE_LEFT);
    check("sub_frame", sub_frame_out, 1'h1);
    $display("test init_gate done");
  endtask

  task automatic t_eye_alt;
    logic e;
    @(negedge clk_in);
    glasses_en_in = 1'h1;
    for (int i = 0; i < 4; i++)
    begin
      e = (i % 2 == 0) ? EYE_LEFT : EYE_RIGHT;
      frame(e, 1'h0, 1'h1, 8, 4);
      expect_px(1, 8, 4);
      check("eye", eye_out, e);
      check("glasses", glasses_sync_out, e);
    end
    check("res_error", res_error_out, 1'h0);
    glasses_en_in = 1'h0;
    repeat (6) @(negedge clk_in);
    check("glasses_off", glasses_sync_out, 1'h0);
    $display("test eye_alt done");
  endtask

  task automatic t_pol_edge;
    set_cfg(1'h0, 1'h0, 1'h1, 1'h0);
    frame(EYE_RIGHT, 1'h0, 1'h0, 8, 4);
    expect_px(1, 8, 4);
    check("eye", eye_out, EYE_RIGHT);
    set_cfg(1'h1, 1'h1, 1'h0, 1'h1);
    $display("test pol_edge done");
  endtask

  task automatic t_res_limit;
    frame(EYE_LEFT, 1'h0, 1'h1, 4, 6);
    expect_px(1, 4, 6);
    frame(EYE_RIGHT, 1'h0, 1'h1, 8, 4);
    expect_px(1, 0, 0);
    check("res_error", res_error_out, 1'h1);
    frame(EYE_LEFT, 1'h0, 1'h1, 8, 4);
    expect_px(1, 8, 4);
    frame(EYE_RIGHT, 1'h0, 1'h1, 1922, 1);
    expect_px(1, 1922, 1);
    $display("test res_limit done");
  endtask

  task automatic t_sync_loss;
    @(negedge clk_in);
    lock_vsync_in = 1'h1;
    frame(EYE_LEFT, 1'h0, 1'h1, 8, 4);
    check("seq_run", seq_run_out, 1'h1);
    check("res_error_clip", res_error_out, 1'h1);
    repeat (60) @(negedge clk_in);
    check("seq_run_hold", seq_run_out, 1'h1);
    repeat (40) @(negedge clk_in);
    check("seq_run_lost", seq_run_out, 1'h0);
    check("led_lost", led_on_out, 1'h0);
    frame(EYE_RIGHT, 1'h0, 1'h1, 8, 4);
    check("seq_run_back", seq_run_out, 1'h1);
    check("led_back", led_on_out, 1'h1);
    check("res_error_back", res_error_out, 1'h0);
    $display("test sync_loss done");
  endtask

  // main sequence; pixel clock runs during reset so both domains clear
  initial
  begin
    {rst_in, vsync_pol_in, hsync_pol_in, use_valid_in} = 4'hf;
    {fall_edge_in, init_done_in, lock_vsync_in, glasses_en_in} = 4'h0;
    {err_total, checks_done, pix_cnt, fs_cnt} = '0;
    video_source_model_i.cfg(1'h1, 1'h1, 1'h0);
    fork
      video_source_model_i.idle(2);
      repeat (6) @(negedge clk_in);
    join
    rst_in = 1'h0;
    video_source_model_i.idle(4);
    t_init_gate();
    t_eye_alt();
    t_pol_edge();
    t_res_limit();
    t_sync_loss();
    report_and_stop();
  end

  // hang guard, well beyond the roughly 150 microseconds the tests need
  initial
  begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule
